// >>> include/ton_seq_pkg.sv
// package: command codes, field layout, reset values and timing constants
package ton_seq_pkg;

    // ------------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_PG_ON       = 8'h5e;
    localparam logic [7:0] CMD_PG_OFF      = 8'h5f;
    localparam logic [7:0] CMD_TURN_ON_DELAY   = 8'h60;
    localparam logic [7:0] CMD_TURN_ON_RISE_TIME    = 8'h61;
    localparam logic [7:0] CMD_TON_LIMIT   = 8'h62;
    localparam logic [7:0] CMD_TON_RESP    = 8'h63;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_PG_ON      = 16'h0000;
    localparam logic [15:0] RST_PG_OFF     = 16'h0000;
    localparam logic [15:0] RST_TURN_ON_DELAY  = 16'h0000;
    localparam logic [15:0] RST_TURN_ON_RISE_TIME   = 16'h0000;
    localparam logic [15:0] RST_TON_LIMIT  = 16'h0000;
    localparam logic [7:0]  RST_TON_RESP   = 8'h80;

    // ------------------------------------------------------------------
    // response byte fields
    // ------------------------------------------------------------------
    localparam int RESP_MODE_HI  = 7;
    localparam int RESP_MODE_LO  = 6;
    localparam int RESP_RETRY_HI = 5;
    localparam int RESP_RETRY_LO = 3;
    localparam int RESP_DLY_HI   = 2;
    localparam int RESP_DLY_LO   = 0;

    localparam logic [1:0] MODE_IGNORE  = 2'h0;
    localparam logic [1:0] MODE_OPERATE = 2'h1;
    localparam logic [1:0] MODE_DISABLE = 2'h2;
    localparam logic [1:0] MODE_LATCH   = 2'h3;

    localparam logic [2:0] RETRY_NONE    = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // ------------------------------------------------------------------
    // linear format fields
    // ------------------------------------------------------------------
    localparam int LIN_EXP_HI  = 15;
    localparam int LIN_EXP_LO  = 11;
    localparam int LIN_MANT_HI = 10;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int TIMER_W       = 24;
    localparam int MS_TIME_NS    = 1000000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
    localparam int DIV_W         = 16;

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_OFF        = 7'b0000001,
        ST_DELAY      = 7'b0000010,
        ST_RISE       = 7'b0000100,
        ST_ON         = 7'b0001000,
        ST_FLT_WAIT   = 7'b0010000,
        ST_RETRY_WAIT = 7'b0100000,
        ST_LATCHED    = 7'b1000000
    } seq_state_t;

endpackage

// >>> verilog/ms_countdown.sv
// millisecond countdown timer with load, stop and expiry pulse
`timescale 1ns/1ps
module ms_countdown
    import ton_seq_pkg::*;
#(
    parameter int W = TIMER_W
)
(
    input  wire logic         i_mclk,
    input  wire logic         i_resetn,
    input  wire logic         i_load,
    input  wire logic         i_stop,
    input  wire logic [W-1:0] i_value,
    input  wire logic         i_tick,
    output logic              o_busy,
    output logic              o_expired
);

    logic [W-1:0] cnt_r;
    wire          zero_load = (i_value == '0);
    wire          last_tick = o_busy && i_tick && (cnt_r == W'(1));

    // a zero load expires on the next edge, so a zero time still moves on
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            cnt_r     <= '0;
            o_busy    <= 1'b0;
            o_expired <= 1'b0;
        end
        else if (i_load)
        begin
            cnt_r     <= i_value;
            o_busy    <= !zero_load;
            o_expired <= zero_load;
        end
        else if (i_stop)
        begin
            o_busy    <= 1'b0;
            o_expired <= 1'b0;
        end
        else
        begin
            o_expired <= last_tick;
            if (last_tick)
                o_busy <= 1'b0;
            if (o_busy && i_tick)
                cnt_r <= cnt_r - W'(1);
        end
    end

endmodule // ms_countdown

// >>> verilog/output_turn_on_sequencer.sv
// turn-on sequencer, power good logic and turn-on timeout fault response
//
// Summary of operation
// - power good asserts when output voltage reaches the turn-on threshold in the on or fault-wait state
// - below turn-off threshold: negate pin if enabled, set status bit
// - after enable, wait programmed turn-on delay before ramping output
// - after delay, ramp output over programmed rise time
// - turn-on longer than limit before undervoltage level is a fault
// - a limit of zero disables the turn-on timeout
// - response code 00 ignores the fault, output keeps running
// - code 01 keeps running for delay, then follows retry field if fault persists
// - code 10 disables output at once, then follows retry field
// - code 11 keeps output off until fault is cleared
// - retry field 000 means no restart, stay off until cleared
// - retry codes give that many restarts, then stay off
// - restart starts are spaced by the decoded delay field times time unit
// - delay field n decodes to two to the n time units
// - time unit comes from the fault time-unit register input
// - retry code 111 retries forever until commanded off
`timescale 1ns/1ps
module output_turn_on_sequencer
    import ton_seq_pkg::*;
#(
    parameter int MS_DIV = MS_CYCLES
)
(
    input  wire logic        i_mclk,
    input  wire logic        i_resetn,
    input  wire logic        i_enable,
    input  wire logic [15:0] i_vout,
    input  wire logic [15:0] i_uv_limit,
    input  wire logic        i_pg_pin_en,
    input  wire logic [7:0]  i_fault_time_unit,
    input  wire logic        i_clear_faults,
    input  wire logic        i_clear_ton_fault,
    input  wire logic        i_cmd_wr,
    input  wire logic        i_cmd_rd,
    input  wire logic [7:0]  i_cmd_code,
    input  wire logic [15:0] i_cmd_wdata,
    output logic [15:0]      o_cmd_rdata,
    output logic             o_cmd_ack,
    output logic             o_cmd_nak,
    output logic             o_power_good_output,
    output logic             o_pg_status,
    output logic             o_output_en,
    output logic             o_ramping,
    output logic             o_ton_fault
);

    // ------------------------------------------------------------------
    // command registers
    // ------------------------------------------------------------------
    logic [15:0] pg_on_r;
    logic [15:0] pg_off_r;
    logic [15:0] turn_on_delay_r;
    logic [15:0] turn_on_rise_time_r;
    logic [15:0] ton_limit_r;
    logic [7:0]  ton_resp_r;

    wire hit_pg_on  = (i_cmd_code == CMD_PG_ON);
    wire hit_pg_off = (i_cmd_code == CMD_PG_OFF);
    wire hit_delay  = (i_cmd_code == CMD_TURN_ON_DELAY);
    wire hit_rise   = (i_cmd_code == CMD_TURN_ON_RISE_TIME);
    wire hit_limit  = (i_cmd_code == CMD_TON_LIMIT);
    wire hit_resp   = (i_cmd_code == CMD_TON_RESP);
    wire hit_any    = hit_pg_on | hit_pg_off | hit_delay | hit_rise
                    | hit_limit | hit_resp;

    wire [15:0] rd_mux = hit_pg_on  ? pg_on_r :
                         hit_pg_off ? pg_off_r :
                         hit_delay  ? turn_on_delay_r :
                         hit_rise   ? turn_on_rise_time_r :
                         hit_limit  ? ton_limit_r :
                         hit_resp   ? {8'h00, ton_resp_r} : 16'h0000;

    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            pg_on_r     <= RST_PG_ON;
            pg_off_r    <= RST_PG_OFF;
            turn_on_delay_r <= RST_TURN_ON_DELAY;
            turn_on_rise_time_r  <= RST_TURN_ON_RISE_TIME;
            ton_limit_r <= RST_TON_LIMIT;
            ton_resp_r  <= RST_TON_RESP;
        end
        else if (i_cmd_wr)
        begin
            if (hit_pg_on)
                pg_on_r <= i_cmd_wdata;
            if (hit_pg_off)
                pg_off_r <= i_cmd_wdata;
            if (hit_delay)
                turn_on_delay_r <= i_cmd_wdata;
            if (hit_rise)
                turn_on_rise_time_r <= i_cmd_wdata;
            if (hit_limit)
                ton_limit_r <= i_cmd_wdata;
            if (hit_resp)
                ton_resp_r <= i_cmd_wdata[7:0];
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            o_cmd_rdata <= 16'h0000;
            o_cmd_ack   <= 1'b0;
            o_cmd_nak   <= 1'b0;
        end
        else
        begin
            o_cmd_ack <= (i_cmd_wr | i_cmd_rd) & hit_any;
            o_cmd_nak <= (i_cmd_wr | i_cmd_rd) & !hit_any;
            if (i_cmd_rd)
                o_cmd_rdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // linear format to whole milliseconds
    // ------------------------------------------------------------------
    // negative mantissas mean no time; large values saturate the timer
    function automatic logic [TIMER_W-1:0] lin_ms(input logic [15:0] v);
        logic signed [4:0] ex;
        logic [10:0]       mant;
        logic [31:0]       wide;
        ex   = v[LIN_EXP_HI:LIN_EXP_LO];
        mant = v[LIN_MANT_HI:0];
        wide = 32'h0;
        if (!mant[LIN_MANT_HI])
        begin
            if (ex >= 0)
                wide = {21'h0, mant} << ex;
            else
                wide = {21'h0, mant} >> (-ex);
        end
        if (wide > 32'(2**TIMER_W - 1))
            lin_ms = '1;
        else
            lin_ms = wide[TIMER_W-1:0];
    endfunction

    // ------------------------------------------------------------------
    // millisecond timebase and input synchroniser
    // ------------------------------------------------------------------
    logic [DIV_W-1:0] div_r;
    logic             tick_r;
    logic             en_s1_r;
    logic             en_s2_r;

    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            div_r   <= '0;
            tick_r  <= 1'b0;
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
        end
        else
        begin
            en_s1_r <= i_enable;
            en_s2_r <= en_s1_r;
            tick_r  <= (div_r == DIV_W'(MS_DIV - 1));
            if (div_r == DIV_W'(MS_DIV - 1))
                div_r <= '0;
            else
                div_r <= div_r + DIV_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // response decode
    // ------------------------------------------------------------------
    wire [1:0] resp_mode  = ton_resp_r[RESP_MODE_HI:RESP_MODE_LO];
    wire [2:0] resp_retry = ton_resp_r[RESP_RETRY_HI:RESP_RETRY_LO];
    wire [2:0] resp_dly   = ton_resp_r[RESP_DLY_HI:RESP_DLY_LO];
    // two to the field value, times the unit: at most 128 * 255 ms
    wire [TIMER_W-1:0] fault_dly_ms =
        (TIMER_W'(i_fault_time_unit) << resp_dly);

    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [2:0] tries_r;
    logic [2:0] tries_nxt;

    wire uv_reached = (i_vout >= i_uv_limit);
    wire clear_req  = i_clear_faults | i_clear_ton_fault;
    // forever beats any count; 000 never restarts
    wire retry_ok   = (resp_retry == RETRY_FOREVER)
                    || ((resp_retry != RETRY_NONE)
                        && (tries_r < resp_retry));
    seq_state_t retry_st;
    assign retry_st = retry_ok ? ST_RETRY_WAIT : ST_LATCHED;

    // ------------------------------------------------------------------
    // timers
    // ------------------------------------------------------------------
    logic ph_busy;
    logic ph_exp;
    logic to_busy;
    logic to_exp;

    wire enter_delay = (state_nxt == ST_DELAY) && (state_r != ST_DELAY);
    wire enter_rise  = (state_nxt == ST_RISE) && (state_r != ST_RISE);
    wire enter_wait  = ((state_nxt == ST_FLT_WAIT)
                        && (state_r != ST_FLT_WAIT))
                    || ((state_nxt == ST_RETRY_WAIT)
                        && (state_r != ST_RETRY_WAIT));
    wire ph_load     = enter_delay | enter_rise | enter_wait;
    wire [TIMER_W-1:0] ph_value =
        enter_delay ? lin_ms(turn_on_delay_r) :
        enter_rise  ? lin_ms(turn_on_rise_time_r)  :
                      fault_dly_ms;

    // timeout runs only with a nonzero limit, from ramp start to uv level
    wire to_load = enter_rise && (ton_limit_r != 16'h0000);
    wire to_stop = uv_reached || (state_r == ST_OFF);

    ms_countdown #(.W(TIMER_W)) u_phase
    (
        .i_mclk    (i_mclk),
        .i_resetn  (i_resetn),
        .i_load    (ph_load),
        .i_stop    (1'b0),
        .i_value   (ph_value),
        .i_tick    (tick_r),
        .o_busy    (ph_busy),
        .o_expired (ph_exp)
    );

    ms_countdown #(.W(TIMER_W)) u_timeout
    (
        .i_mclk    (i_mclk),
        .i_resetn  (i_resetn),
        .i_load    (to_load),
        .i_stop    (to_stop),
        .i_value   (lin_ms(ton_limit_r)),
        .i_tick    (tick_r),
        .o_busy    (to_busy),
        .o_expired (to_exp)
    );

    wire running   = (state_r == ST_RISE) || (state_r == ST_ON);
    wire fault_evt = to_exp && running && !uv_reached;
    // an ignored fault in the last rise cycle must not swallow the ramp end
    wire rise_end  = (state_r == ST_RISE) && ph_exp;

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        tries_nxt = tries_r;
        unique case (state_r)
            ST_OFF:
            begin
                tries_nxt = 3'h0;
                if (en_s2_r)
                    state_nxt = ST_DELAY;
            end
            ST_DELAY:
                if (ph_exp)
                    state_nxt = ST_RISE;
            ST_RISE, ST_ON:
            begin
                if (fault_evt)
                begin
                    unique case (resp_mode)
                        MODE_IGNORE:
                            state_nxt = rise_end ? ST_ON : state_r;
                        MODE_OPERATE: state_nxt = ST_FLT_WAIT;
                        MODE_DISABLE: state_nxt = retry_st;
                        MODE_LATCH:   state_nxt = ST_LATCHED;
                    endcase
                end
                else if (rise_end)
                    state_nxt = ST_ON;
            end
            ST_FLT_WAIT:
                if (ph_exp)
                    state_nxt = uv_reached ? ST_ON : retry_st;
            ST_RETRY_WAIT:
                if (ph_exp)
                    state_nxt = ST_DELAY;
            ST_LATCHED:
                if (clear_req)
                    state_nxt = ST_OFF;
        endcase
        if ((state_nxt == ST_RETRY_WAIT) && (state_r != ST_RETRY_WAIT)
            && (tries_r != 3'h7))
            tries_nxt = tries_r + 3'h1;
        // commanded off ends any sequence and also clears a latch-off
        if (!en_s2_r)
            state_nxt = ST_OFF;
    end

    logic pg_r;
    wire  out_on   = (state_r == ST_ON) || (state_r == ST_FLT_WAIT);
    wire  pg_set   = out_on && (i_vout >= pg_on_r);
    wire  pg_clr   = !out_on || (i_vout < pg_off_r);
    wire  pg_nxt   = pg_clr ? 1'b0 : (pg_set | pg_r);
    wire  en_nxt   = (state_nxt == ST_RISE) || (state_nxt == ST_ON)
                   || (state_nxt == ST_FLT_WAIT);

    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            state_r             <= ST_OFF;
            tries_r             <= 3'h0;
            pg_r                <= 1'b0;
            o_power_good_output <= 1'b0;
            o_pg_status         <= 1'b1;
            o_output_en         <= 1'b0;
            o_ramping           <= 1'b0;
            o_ton_fault         <= 1'b0;
        end
        else
        begin
            state_r             <= state_nxt;
            tries_r             <= tries_nxt;
            pg_r                <= pg_nxt;
            o_power_good_output <= pg_nxt & i_pg_pin_en;
            o_pg_status         <= !pg_nxt;
            o_output_en         <= en_nxt;
            o_ramping           <= (state_nxt == ST_RISE);
            // a fault in the clearing cycle still sets the flag
            o_ton_fault         <= fault_evt
                                 | (o_ton_fault & !clear_req);
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    pg_rise_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        $rose(pg_r) |-> $past(out_on)
                        && ($past(i_vout) >= $past(pg_on_r)))
        else $error("power good rose without reaching threshold");

    pg_fall_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (i_vout < pg_off_r) |=> !o_power_good_output && o_pg_status)
        else $error("power good not negated below off threshold");

    delay_end_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (state_r == ST_DELAY) && ph_exp && en_s2_r
        |=> (state_r == ST_RISE) && o_ramping)
        else $error("ramp did not start at delay expiry");

    rise_hold_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (state_r == ST_RISE) && ph_busy && !fault_evt && en_s2_r
        |=> o_ramping && o_output_en)
        else $error("ramp ended before rise time");

    no_limit_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (ton_limit_r == 16'h0000) && $stable(ton_limit_r)
        && (state_r == ST_RISE) && $past(state_r == ST_RISE)
        |-> !to_busy)
        else $error("timeout running with zero limit");

    ignore_run_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        fault_evt && (resp_mode == MODE_IGNORE) && en_s2_r
        |=> o_output_en && o_ton_fault)
        else $error("ignored fault interrupted output");

    disable_off_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        fault_evt && (resp_mode == MODE_DISABLE)
        |=> !o_output_en)
        else $error("output not disabled on fault");

    latch_hold_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (state_r == ST_LATCHED) && !clear_req && en_s2_r
        |=> (state_r == ST_LATCHED) && !o_output_en)
        else $error("latched output restarted without clear");

    no_retry_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        fault_evt && (resp_mode == MODE_DISABLE)
        && (resp_retry == RETRY_NONE) && en_s2_r
        |=> state_r == ST_LATCHED)
        else $error("restart attempted with zero retry setting");

endmodule // output_turn_on_sequencer

// >>> verification/pmbus_host_model.sv
// host model driving the sequencer's command port
`timescale 1ns/1ps
module pmbus_host_model
(
    input  wire logic   i_mclk,
    output logic        o_wr,
    output logic        o_rd,
    output logic [7:0]  o_code,
    output logic [15:0] o_wdata
);
    logic [17:0] exp_q[$];

    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_code = 8'hff;
        o_wdata = 16'hffff;
    end

    // one-cycle strobe; released lines are inverted so a late sample fails
    task automatic access(input logic rd, input logic [7:0] code,
                          input logic [15:0] d, input logic nak);
        @(negedge i_mclk);
        o_wr = ~rd;
        o_rd = rd;
        o_code = code;
        o_wdata = d;
        exp_q.push_back({rd, nak, d});
        @(negedge i_mclk);
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_code = ~code;
        o_wdata = ~d;
    endtask
endmodule // pmbus_host_model

// >>> verification/output_turn_on_sequencer_tb.sv
// self-checking bench for the turn-on sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module output_turn_on_sequencer_tb;
    import ton_seq_pkg::*;
    localparam int MS = 4;
    logic        i_mclk, i_resetn, i_enable, i_pg_pin_en;
    logic        i_clear_faults, i_clear_ton_fault, wr, rd;
    logic [15:0] i_vout, i_uv_limit, wdata, rdata, d;
    logic [7:0]  i_fault_time_unit, code;
    logic        ack, nak, pg, pg_st, o_output_en, o_ramping, o_ton_fault;
    logic [17:0] note;
    logic [7:0]  resp[6] = '{8'h08, 8'h48, 8'h8a, 8'hc8, 8'h80, 8'hb8};
    int          tries[6] = '{0, 1, 1, 0, 0, 3};
    int          err_count = 0, checked = 0, n, fd;

    always #12.5 i_mclk = ~i_mclk;

    pmbus_host_model host (.i_mclk(i_mclk), .o_wr(wr), .o_rd(rd),
                           .o_code(code), .o_wdata(wdata));

    output_turn_on_sequencer #(.MS_DIV(MS)) dut (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_enable(i_enable),
        .i_vout(i_vout), .i_uv_limit(i_uv_limit),
        .i_pg_pin_en(i_pg_pin_en), .i_fault_time_unit(i_fault_time_unit),
        .i_clear_faults(i_clear_faults),
        .i_clear_ton_fault(i_clear_ton_fault), .i_cmd_wr(wr),
        .i_cmd_rd(rd), .i_cmd_code(code), .i_cmd_wdata(wdata),
        .o_cmd_rdata(rdata), .o_cmd_ack(ack), .o_cmd_nak(nak),
        .o_power_good_output(pg), .o_pg_status(pg_st),
        .o_output_en(o_output_en), .o_ramping(o_ramping),
        .o_ton_fault(o_ton_fault));

    // ------------------------------------------------------------------
    // command answers against the host's notes
    // ------------------------------------------------------------------
    always @(negedge i_mclk)
        if (ack === 1'b1 || nak === 1'b1)
        begin
            if (host.exp_q.size() == 0)
                `CHK(1'b0, 1'b1)
            else
            begin
                note = host.exp_q.pop_front();
                `CHK(nak, note[16])
                if (note[17])
                    `CHK(rdata, note[15:0])
            end
        end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic logic sig(input int s);
        return s == 0 ? o_ramping : s == 1 ? o_output_en : o_ton_fault;
    endfunction

    // bounded wait; n returns the cycles spent
    task automatic wait_out(input int s, input logic v, output int c);
        c = 0;
        while (sig(s) !== v)
        begin
            @(negedge i_mclk);
            c++;
            if (c > 400)
            begin
                err_count++;
                report_and_stop();
            end
        end
    endtask

    task automatic w(input logic [7:0] c, input logic [15:0] v);
        host.access(1'b0, c, v, 1'b0);
    endtask

    task automatic pulse(input int s);
        if (s == 0)
            i_clear_faults = 1'b1;
        else
            i_clear_ton_fault = 1'b1;
        @(negedge i_mclk);
        i_clear_faults = 1'b0;
        i_clear_ton_fault = 1'b0;
    endtask

    initial
    begin
        {i_mclk, i_resetn, i_enable, i_clear_faults} = 4'h0;
        {i_clear_ton_fault, i_pg_pin_en} = 2'b01;
        i_vout = 16'h0000;
        i_uv_limit = 16'h0040;
        i_fault_time_unit = 8'h01;
        void'($urandom(32'heee156d3));
        repeat (3) @(negedge i_mclk);
        i_resetn = 1'b1;
        for (int c = 0; c < 6; c++)
        begin
            host.access(1'b1, CMD_PG_ON + 8'(c),
                        c == 5 ? 16'h0080 : 16'h0000, 1'b0);
            d = 16'($urandom);
            w(CMD_PG_ON + 8'(c), d);
            host.access(1'b1, CMD_PG_ON + 8'(c),
                        c == 5 ? {8'h00, d[7:0]} : d, 1'b0);
        end
        host.access(1'b0, 8'h64, 16'h1234, 1'b1);
        host.access(1'b1, 8'h64, 16'h0000, 1'b1);
        $display("test registers done");
        w(CMD_PG_ON, 16'h0100);
        w(CMD_PG_OFF, 16'h0080);
        w(CMD_TURN_ON_DELAY, 16'h0003);
        w(CMD_TURN_ON_RISE_TIME, 16'h0002);
        w(CMD_TON_LIMIT, 16'h0000);
        i_enable = 1'b1;
        wait_out(0, 1'b1, n);
        `CHK(n inside {[11:20]}, 1'b1)
        `CHK(o_output_en, 1'b1)
        wait_out(0, 1'b0, n);
        `CHK(n inside {[4:13]}, 1'b1)
        repeat (60) @(negedge i_mclk);
        `CHK(o_ton_fault, 1'b0)
        i_vout = 16'h0100;
        repeat (3) @(negedge i_mclk);
        `CHK({pg, pg_st}, 2'b10)
        i_pg_pin_en = 1'b0;
        repeat (3) @(negedge i_mclk);
        `CHK({pg, pg_st}, 2'b00)
        i_pg_pin_en = 1'b1;
        i_vout = 16'h007f;
        repeat (3) @(negedge i_mclk);
        `CHK({pg, pg_st}, 2'b01)
        i_enable = 1'b0;
        i_vout = 16'h0000;
        $display("test power good done");
        w(CMD_TURN_ON_DELAY, 16'h0000);
        w(CMD_TURN_ON_RISE_TIME, 16'h0014);
        w(CMD_TON_LIMIT, 16'h0001);
        foreach (resp[e])
        begin
            w(CMD_TON_RESP, {8'h00, resp[e]});
            pulse(0);
            i_fault_time_unit = 8'(e % 2 + 1);
            fd = (MS * i_fault_time_unit) << resp[e][2:0];
            i_enable = 1'b1;
            wait_out(0, 1'b1, n);
            wait_out(2, 1'b1, n);
            `CHK(n inside {[1:10]}, 1'b1)
            repeat (2) @(negedge i_mclk);
            `CHK(o_output_en, resp[e][7:6] < MODE_DISABLE)
            for (int j = 0; j < tries[e]; j++)
            begin
                wait_out(1, 1'b0, n);
                wait_out(1, 1'b1, n);
                `CHK(n inside {[fd - 4:fd + 6]}, 1'b1)
            end
            if (resp[e][5:3] == RETRY_FOREVER)
                i_enable = 1'b0;
            if (resp[e][7:6] != MODE_IGNORE)
                wait_out(1, 1'b0, n);
            repeat (150) @(negedge i_mclk);
            `CHK(o_output_en, resp[e][7:6] == MODE_IGNORE)
            if (resp[e][7:6] == MODE_LATCH)
            begin
                pulse(1);
                wait_out(1, 1'b1, n);
                `CHK(n < 20, 1'b1)
            end
            i_enable = 1'b0;
            repeat (10) @(negedge i_mclk);
            pulse(0);
            @(negedge i_mclk);
            `CHK(o_ton_fault, 1'b0)
            $display("test response %h done", resp[e]);
        end
        `CHK(host.exp_q.size(), 0)
        report_and_stop();
    end
endmodule // output_turn_on_sequencer_tb
